// >>> design/adc_serial_control.sv
// serial control, track/hold timing and result output of the converter
// assumes sclk, cs_n and din are synchronous to mclk and much slower
`timescale 1ns/1ps
`default_nettype none
module adc_serial_control
  import adc_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic hard_shutdown_n,
  input wire logic comparator_high,
  output logic dout,
  output logic dout_oe,
  output logic conversion_strobe_out,
  output logic strobe_oe,
  output logic track_switch_closed,
  output logic cap_on_positive,
  output logic [7:0] pos_channel,
  output logic [7:0] neg_channel,
  output logic neg_on_common,
  output logic [11:0] dac_code,
  output logic polarity_select,
  output logic input_mode_select,
  output logic [1:0] power_mode,
  output logic converting
);
  logic sclk_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_prev;
  logic cs_fall;
  frame_e frame;
  frame_e next_frame;
  logic [3:0] bit_count;
  logic [3:0] next_bit_count;
  logic [7:0] shift_reg;
  logic [7:0] next_shift_reg;
  conv_e conv;
  conv_e next_conv;
  logic [3:0] conv_count;
  logic [3:0] next_conv_count;
  logic [2:0] chan_select;
  logic [2:0] next_chan_select;
  logic next_polarity_select;
  logic next_input_mode_select;
  logic [1:0] power_request;
  logic [1:0] next_power_request;
  logic [1:0] next_power_mode;
  logic next_track_switch_closed;
  logic next_dout;
  logic next_conversion_strobe_out;
  logic start_ok;
  logic sar_load;
  logic sar_decide;
  logic sar_bit;

  assign sclk_rise = sclk & ~sclk_prev;
  assign sclk_fall = ~sclk & sclk_prev;
  assign cs_fall = ~cs_n & cs_prev;
  assign dout_oe = ~cs_n;
  assign strobe_oe = ~cs_n;
  assign converting = (conv == CONV_RUN);
  // the capacitor sits on the negative input only while converting
  assign cap_on_positive = ~converting;
  assign start_ok = (conv == CONV_IDLE) || (conv_count >= RESTART_COUNT);
  assign sar_load = sclk_fall && (frame == FRAME_SHIFT)
    && (bit_count == LAST_BIT_COUNT);
  assign sar_decide = sclk_rise && converting
    && (conv_count >= STROBE_COUNT) && (conv_count < LAST_DATA_COUNT);

  // framing of the control byte
  always_comb
  begin
    next_frame = frame;
    next_bit_count = bit_count;
    next_shift_reg = shift_reg;
    if (!hard_shutdown_n)
    begin
      next_frame = FRAME_HUNT;
      next_bit_count = 4'h0;
    end
    else if (sclk_rise && !cs_n)
    begin
      next_shift_reg = {shift_reg[6:0], din};
      case (frame)
        FRAME_HUNT:
        begin
          // zeros pass with no effect until a start bit
          if (din && start_ok)
          begin
            next_frame = FRAME_SHIFT;
            next_bit_count = 4'h1;
          end
        end
        FRAME_SHIFT:
        begin
          if (bit_count < LAST_BIT_COUNT)
          begin
            next_bit_count = bit_count + 4'h1;
          end
        end
        default:
        begin
          next_frame = FRAME_HUNT;
          next_bit_count = 4'h0;
        end
      endcase
    end
    else if (sclk_fall && (frame == FRAME_SHIFT)
      && (bit_count == LAST_BIT_COUNT))
    begin
      next_frame = FRAME_HUNT;
      next_bit_count = 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame <= FRAME_HUNT;
      bit_count <= 4'h0;
      shift_reg <= SHIFT_RESET;
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end
    else
    begin
      frame <= next_frame;
      bit_count <= next_bit_count;
      shift_reg <= next_shift_reg;
      sclk_prev <= sclk;
      cs_prev <= cs_n;
    end
  end

  // latched control fields and track/hold
  always_comb
  begin
    next_chan_select = chan_select;
    next_polarity_select = polarity_select;
    next_input_mode_select = input_mode_select;
    next_power_request = power_request;
    next_power_mode = power_mode;
    next_track_switch_closed = track_switch_closed;
    if (sar_load)
    begin
      // an all-ones byte lands here as channel seven, single, normal
      next_chan_select = shift_reg[SEL_HI_POS:SEL_LO_POS];
      next_polarity_select = shift_reg[POLARITY_POS];
      next_input_mode_select = shift_reg[INPUT_MODE_POS];
      next_power_request = shift_reg[POWER_HI_POS:POWER_LO_POS];
      next_power_mode = PWR_NORMAL;
      next_track_switch_closed = 1'b0;
    end
    else if (sclk_fall && (frame == FRAME_SHIFT)
      && (bit_count == TRACK_BIT_COUNT))
    begin
      next_track_switch_closed = 1'b1;
      next_power_mode = PWR_NORMAL;
    end
    else if (sclk_rise && converting && (conv_count == LAST_DATA_COUNT))
    begin
      next_track_switch_closed = 1'b1;
      next_power_mode = power_request;
    end
    if (!hard_shutdown_n)
    begin
      next_track_switch_closed = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_select <= SEL_RESET;
      polarity_select <= 1'b1;
      input_mode_select <= 1'b1;
      power_request <= PWR_NORMAL;
      power_mode <= PWR_NORMAL;
      track_switch_closed <= 1'b0;
    end
    else
    begin
      chan_select <= next_chan_select;
      polarity_select <= next_polarity_select;
      input_mode_select <= next_input_mode_select;
      power_request <= next_power_request;
      power_mode <= next_power_mode;
      track_switch_closed <= next_track_switch_closed;
    end
  end

  // conversion sequence, strobe and result bits
  always_comb
  begin
    next_conv = conv;
    next_conv_count = conv_count;
    next_dout = dout;
    next_conversion_strobe_out = conversion_strobe_out;
    if (cs_fall)
    begin
      next_conversion_strobe_out = 1'b0;
    end
    if (!hard_shutdown_n)
    begin
      next_conv = CONV_IDLE;
      next_conv_count = 4'h0;
      next_dout = 1'b0;
      next_conversion_strobe_out = 1'b0;
    end
    else if (sar_load)
    begin
      next_conv = CONV_RUN;
      next_conv_count = 4'h0;
    end
    else if (sclk_rise)
    begin
      case (conv)
        CONV_IDLE:
        begin
          next_dout = 1'b0;
          next_conversion_strobe_out = 1'b0;
        end
        CONV_RUN:
        begin
          next_conv_count = conv_count + 4'h1;
          // three leading zeros, twelve decisions, one trailing zero
          next_conversion_strobe_out = (conv_count + 4'h1 == STROBE_COUNT);
          if ((conv_count + 4'h1 >= FIRST_DATA_COUNT)
            && (conv_count + 4'h1 <= LAST_DATA_COUNT))
          begin
            next_dout = sar_bit;
          end
          else
          begin
            next_dout = 1'b0;
          end
          if (conv_count + 4'h1 == END_COUNT)
          begin
            next_conv = CONV_IDLE;
            next_conv_count = 4'h0;
          end
        end
        default:
        begin
          next_conv = CONV_IDLE;
          next_conv_count = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv <= CONV_IDLE;
      conv_count <= 4'h0;
      dout <= 1'b0;
      conversion_strobe_out <= 1'b0;
    end
    else
    begin
      conv <= next_conv;
      conv_count <= next_conv_count;
      dout <= next_dout;
      conversion_strobe_out <= next_conversion_strobe_out;
    end
  end

  channel_select_decode u_decode (
    .chan_select(chan_select),
    .input_mode_select(input_mode_select),
    .pos_channel(pos_channel),
    .neg_channel(neg_channel),
    .neg_on_common(neg_on_common)
  );

  sar_register u_sar (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(sar_load),
    .decide(sar_decide),
    .comparator_high(comparator_high),
    .polarity_select(polarity_select),
    .dac_code(dac_code),
    .out_bit(sar_bit)
  );
endmodule // adc_serial_control
`default_nettype wire

// >>> include/adc_ctrl_pkg.sv
// constants shared by the serial converter control logic
// assumes one system clock at 50 MHz sampling the serial pins
package adc_ctrl_pkg;
  // system clock
  localparam int MCLK_PERIOD_NS = 20;
  // least acquisition window the host must leave, per supply variant
  localparam int T_ACQ_5V_NS = 468;
  localparam int T_ACQ_3V_NS = 625;
  localparam int ACQ_5V_CYCLES = (T_ACQ_5V_NS + MCLK_PERIOD_NS - 1)
    / MCLK_PERIOD_NS;
  localparam int ACQ_3V_CYCLES = (T_ACQ_3V_NS + MCLK_PERIOD_NS - 1)
    / MCLK_PERIOD_NS;
  // control byte layout
  localparam int CTRL_BITS = 8;
  localparam int START_POS = 7;
  localparam int SEL_HI_POS = 6;
  localparam int SEL_LO_POS = 4;
  localparam int POLARITY_POS = 3;
  localparam int INPUT_MODE_POS = 2;
  localparam int POWER_HI_POS = 1;
  localparam int POWER_LO_POS = 0;
  // framing counts, in sclk edges
  localparam logic [3:0] TRACK_BIT_COUNT = 4'h5;
  localparam logic [3:0] LAST_BIT_COUNT = 4'h8;
  localparam logic [3:0] RESTART_COUNT = 4'h8;
  localparam logic [3:0] STROBE_COUNT = 4'h2;
  localparam logic [3:0] FIRST_DATA_COUNT = 4'h3;
  localparam logic [3:0] LAST_DATA_COUNT = 4'he;
  localparam logic [3:0] END_COUNT = 4'hf;
  // successive approximation
  localparam int SAR_BITS = 12;
  localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
  // power modes
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_FAST_DOWN = 2'h1;
  localparam logic [1:0] PWR_REDUCED = 2'h2;
  localparam logic [1:0] PWR_NORMAL = 2'h3;
  // reset values
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [2:0] SEL_RESET = 3'h0;
  // state machines
  typedef enum logic [1:0] {
    FRAME_HUNT = 2'b01,
    FRAME_SHIFT = 2'b10
  } frame_e;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_RUN = 2'b10
  } conv_e;
endpackage

// >>> design/channel_select_decode.sv
// input multiplexer selection from the latched control fields
// assumes fields are held stable for the whole conversion
`timescale 1ns/1ps
`default_nettype none
module channel_select_decode
  import adc_ctrl_pkg::*;
(
  input wire logic [2:0] chan_select,
  input wire logic input_mode_select,
  output logic [7:0] pos_channel,
  output logic [7:0] neg_channel,
  output logic neg_on_common
);
  function automatic logic [7:0] chan_onehot(input logic [2:0] idx);
    chan_onehot = 8'h01 << idx;
  endfunction

  always_comb
  begin
    // even channels on low codes, odd channels on high codes
    pos_channel = chan_onehot({chan_select[1:0], chan_select[2]});
    if (input_mode_select)
    begin
      neg_channel = 8'h00;
      neg_on_common = 1'b1;
    end
    else
    begin
      // pair partner takes the other polarity
      neg_channel = chan_onehot({chan_select[1:0], ~chan_select[2]});
      neg_on_common = 1'b0;
    end
  end
endmodule // channel_select_decode
`default_nettype wire

// >>> design/sar_register.sv
// successive approximation register and output bit coding
// assumes load and decide are one-cycle pulses, never together
`timescale 1ns/1ps
`default_nettype none
module sar_register
  import adc_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic decide,
  input wire logic comparator_high,
  input wire logic polarity_select,
  output logic [11:0] dac_code,
  output logic out_bit
);
  logic [11:0] pointer;
  logic [11:0] next_pointer;
  logic [11:0] next_dac_code;

  // bipolar gives two's complement by flipping the first decision
  assign out_bit = comparator_high ^ (~polarity_select & pointer[11]);

  always_comb
  begin
    next_pointer = pointer;
    next_dac_code = dac_code;
    if (load)
    begin
      next_pointer = SAR_FIRST_TRIAL;
      next_dac_code = SAR_FIRST_TRIAL;
    end
    else if (decide)
    begin
      next_pointer = pointer >> 1;
      next_dac_code = (comparator_high ? dac_code : dac_code & ~pointer)
        | (pointer >> 1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pointer <= 12'h000;
      dac_code <= 12'h000;
    end
    else
    begin
      pointer <= next_pointer;
      dac_code <= next_dac_code;
    end
  end
endmodule // sar_register
`default_nettype wire

// >>> tb/adc_serial_control_monitor.sv
// port checker for the serial converter control block
// assumes bind onto adc_serial_control, one mclk domain
`timescale 1ns/1ps
`default_nettype none
module adc_serial_control_monitor
  import adc_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic hard_shutdown_n,
  input wire logic dout,
  input wire logic conversion_strobe_out,
  input wire logic track_switch_closed,
  input wire logic cap_on_positive,
  input wire logic [7:0] pos_channel,
  input wire logic [7:0] neg_channel,
  input wire logic neg_on_common,
  input wire logic [11:0] dac_code,
  input wire logic polarity_select,
  input wire logic input_mode_select,
  input wire logic converting
);
  logic sclk_q;
  logic [1:0] strobe_rises;
  logic rise;
  logic fall;
  assign rise = sclk & ~sclk_q;
  assign fall = ~sclk & sclk_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q <= 1'b0;
      strobe_rises <= 2'h0;
    end
    else
    begin
      sclk_q <= sclk;
      if (!conversion_strobe_out)
        strobe_rises <= 2'h0;
      else if (rise && strobe_rises != 2'h3)
        strobe_rises <= strobe_rises + 2'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_after_rise;
    $past(rise);
  endsequence
  sequence s_after_fall;
    $past(fall);
  endsequence
  dout_edge_a: assert property (
    $changed(dout) && $past(hard_shutdown_n) |-> s_after_rise)
    else $error("dout moved without sclk rise");
  strobe_edge_a: assert property (
    $rose(conversion_strobe_out) |-> s_after_rise)
    else $error("strobe rose without sclk rise");
  strobe_len_a: assert property (
    $fell(conversion_strobe_out) && $past(hard_shutdown_n) && $past(rise)
    |-> $past(strobe_rises) == 2'h0)
    else $error("strobe not one sclk period");
  track_open_a: assert property (
    $rose(track_switch_closed) && !$past(converting)
    |-> s_after_fall ##0 !converting)
    else $error("tracking began off a falling edge");
  hold_start_a: assert property (
    $rose(converting) |-> s_after_fall ##0
    (!track_switch_closed && dac_code == SAR_FIRST_TRIAL))
    else $error("hold entry wrong");
  cap_back_a: assert property (
    $fell(converting) && $past(hard_shutdown_n)
    |-> s_after_rise ##0 (cap_on_positive && track_switch_closed))
    else $error("capacitor not back on positive input");
  single_mux_a: assert property (
    input_mode_select |-> neg_on_common && neg_channel == 8'h00
    && $onehot(pos_channel))
    else $error("single-ended selection wrong");
  diff_mux_a: assert property (
    !input_mode_select |-> !neg_on_common && $onehot(pos_channel)
    && neg_channel == (((pos_channel & 8'h55) << 1)
    | ((pos_channel & 8'haa) >> 1)))
    else $error("differential pair wrong");
  fields_hold_a: assert property (
    converting && $past(converting) |-> $stable(polarity_select)
    && $stable(input_mode_select) && $stable(pos_channel))
    else $error("fields moved during conversion");
endmodule // adc_serial_control_monitor
bind adc_serial_control adc_serial_control_monitor mon_u (
  .mclk, .rst_n, .sclk, .hard_shutdown_n, .dout, .conversion_strobe_out,
  .track_switch_closed, .cap_on_positive, .pos_channel, .neg_channel,
  .neg_on_common, .dac_code, .polarity_select, .input_mode_select,
  .converting
);
`default_nettype wire

// >>> tb/spi_host_model.sv
// serial master model: clock idles low, samples dout on rise
// assumes 50 MHz mclk; all pin changes just after an mclk edge
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
  input wire logic mclk,
  input wire logic dout,
  input wire logic strobe,
  output logic sclk,
  output logic cs_n,
  output logic din
);
  localparam int HALF = 4;
  logic [7:0] strobe_bits;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic sel(input logic hi);
    @(posedge mclk);
    cs_n <= hi;
    if (hi)
      din <= ~din;
    repeat (HALF) @(posedge mclk);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      din <= tx[i];
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b1;
      rx[i] = dout;
      strobe_bits[i] = strobe;
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b0;
    end
  endtask
endmodule // spi_host_model
`default_nettype wire

// >>> tb/adc_serial_control_tb.sv
// self-checking bench for the serial converter control block
// assumes host model on the serial pins, comparator from vin
`timescale 1ns/1ps
`default_nettype none
module adc_serial_control_tb
  import adc_ctrl_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hard_shutdown_n;
  logic comparator_high;
  logic [11:0] vin = 12'h000;
  logic sclk, cs_n, din, dout, dout_oe, conversion_strobe_out;
  logic strobe_oe, track_switch_closed, cap_on_positive;
  logic neg_on_common, polarity_select, input_mode_select, converting;
  logic [7:0] pos_channel, neg_channel;
  logic [11:0] dac_code;
  logic [1:0] power_mode;
  int num_errors = 0;
  int check_count = 0;
  localparam logic [2:0] CH_OF_SEL [8] = '{3'h0, 3'h2, 3'h4, 3'h6,
    3'h1, 3'h3, 3'h5, 3'h7};
  always #10 mclk = ~mclk;
  always @(posedge mclk)
    comparator_high <= (vin >= dac_code);
  spi_host_model host_u (
    .mclk,
    .dout,
    .strobe(conversion_strobe_out),
    .sclk,
    .cs_n,
    .din
  );
  adc_serial_control dut_u (
    .mclk, .rst_n, .sclk, .cs_n, .din, .hard_shutdown_n,
    .comparator_high, .dout, .dout_oe, .conversion_strobe_out,
    .strobe_oe, .track_switch_closed, .cap_on_positive, .pos_channel,
    .neg_channel, .neg_on_common, .dac_code, .polarity_select,
    .input_mode_select, .power_mode, .converting
  );
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conv(input logic [7:0] ctl, input logic lead,
                      output logic [15:0] res);
    logic [7:0] b;
    logic [7:0] c;
    host_u.sel(1'b0);
    if (lead)
      host_u.xfer(8'h00, b);
    host_u.xfer(ctl, b);
    host_u.xfer(8'h00, b);
    chk(host_u.strobe_bits, 8'h20);
    host_u.xfer(8'h00, c);
    host_u.sel(1'b1);
    res = {b, c};
  endtask
  task automatic t_reset();
    chk({pos_channel, neg_on_common, power_mode, converting,
         cap_on_positive, dout_oe, strobe_oe},
        {8'h01, 1'b1, 2'h3, 4'b0100});
    $display("test reset done");
  endtask
  task automatic t_modes();
    logic [15:0] r;
    logic [11:0] e;
    logic [2:0] ch;
    for (int i = 0; i < 16; i++)
    begin
      vin <= 12'h1a5 + 12'(i * 257);
      conv({1'b1, i[2:0], i[0], i[3], i[1:0]}, i == 9, r);
      e = i[0] ? vin : vin ^ 12'h800;
      ch = CH_OF_SEL[i[2:0]];
      chk(r, {3'h0, e, 1'b0});
      chk(pos_channel, 16'(8'h01 << ch));
      chk(neg_channel, i[3] ? 16'h0000 : 16'(8'h01 << (ch ^ 3'h1)));
      chk(neg_on_common, i[3]);
      chk(power_mode, i[1:0]);
      chk({polarity_select, input_mode_select}, {i[0], i[3]});
      chk({converting, cap_on_positive, track_switch_closed}, 3'b011);
    end
    $display("test modes done");
  endtask
  task automatic t_ones();
    logic [7:0] b;
    logic [7:0] c;
    host_u.sel(1'b0);
    host_u.xfer(8'hff, b);
    host_u.xfer(8'hff, b);
    host_u.xfer(8'hff, c);
    chk({b, c}, {3'h0, vin, 1'b0});
    host_u.xfer(8'hff, b);
    chk({pos_channel, neg_on_common, polarity_select, power_mode},
        {8'h80, 1'b1, 1'b1, 2'h3});
    chk({converting, dout_oe, strobe_oe}, 3'h7);
    host_u.sel(1'b1);
    $display("test ones done");
  endtask
  task automatic t_shut();
    logic [7:0] b;
    host_u.sel(1'b0);
    host_u.xfer(8'hff, b);
    host_u.xfer(8'h00, b);
    chk(converting, 1'b1);
    hard_shutdown_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({converting, conversion_strobe_out, dout, cap_on_positive,
         track_switch_closed}, 5'h02);
    hard_shutdown_n <= 1'b1;
    host_u.sel(1'b1);
    $display("test shutdown done");
  endtask
  initial
  begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    end_of_test();
  end
  initial
  begin
    hard_shutdown_n <= 1'b1;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_modes();
    t_ones();
    t_shut();
    end_of_test();
  end
endmodule // adc_serial_control_tb
`default_nettype wire
